/* File: rtl/rmsl_map.sv */
// Address map decode, internal RAM, display RAM and misc size registers.
// Assumes the CPU holds a request until o_ready and accesses are aligned.
`timescale 1ns/1ps
// Contract
// (R01) 2 KB internal RAM at zero, single cycle
// (R02) Software avoids top 64 bytes when debugging
// (R03) Size select codes 5,4,3 limit RAM
// (R04) Debug mode forces full 2 KB
// (R05) Size writes need unlock key held
// (R06) Software keeps key locked otherwise
// (R07) Present size field reads 2 KB code
// (R08) Debug base select bit, resets zero
// (R09) 20-byte display RAM, 16-bit, single cycle
// (R10) Decode 1 KB and 4 KB peripheral areas
// (R11) Top 1 KB is core I/O window
// (R12) Misc registers are a 16-bit device
// (R13) Split accesses by device width
// (R14) Internal RAM is a 32-bit device
// (R15) RAM beyond limit not written or read
// (R16) Reserved bits zero, reserved codes ignored
module rmsl_map
  import rmsl_pkg::*;
#(
  parameter int RAM_WORDS = RMSL_RAM_WORDS
) (
  input  wire logic        i_mclk,        // Core clock, 250 MHz
  input  wire logic        i_resetn,      // Async reset, active low
  input  wire logic        i_debug_mode,  // Core is in debug mode
  input  wire logic        i_rd,          // CPU read request
  input  wire logic        i_wr,          // CPU write request
  input  wire logic [1:0]  i_size,        // 0: 8, 1: 16, 2: 32 bit
  input  wire logic [23:0] i_addr,        // CPU byte address
  input  wire logic [31:0] i_wdata,       // CPU write data, low aligned
  input  wire logic [15:0] i_ext_rdata,   // Peripheral read data
  output logic      [31:0] o_rdata,       // CPU read data
  output logic             o_ready,       // Access done pulse
  output logic             o_ext_req,     // Peripheral beat strobe
  output logic             o_ext_we,      // Peripheral beat is write
  output logic      [1:0]  o_ext_area,    // 0: area 1, 1: area 2, 2: core
  output logic      [23:0] o_ext_addr,    // Peripheral beat address
  output logic      [1:0]  o_ext_be,      // Peripheral byte enables
  output logic      [15:0] o_ext_wdata,   // Peripheral write data
  output logic      [23:0] o_debug_base   // Debug base address
);

  // Sequencer state
  rmsl_state_t state_reg, state_next;     // Run or answer cycle
  logic [1:0]  beat_reg;                  // Beat number in access
  logic [31:0] acc_reg;                   // Read data gathered so far
  logic [31:0] rdata_reg;                 // Read data to CPU
  logic        ready_reg;                 // Answer pulse
  // Misc registers
  logic [15:0] key_reg;                   // Protect key
  logic [2:0]  sel_reg;                   // Size select
  logic        dbgsel_reg;                // Debug base select
  // Internal RAM storage
  logic [31:0] ram [RAM_WORDS];

  // Request and area decode on the access base address
  wire req      = (i_rd | i_wr) & (state_reg == RMSL_ST_RUN);
  wire in_ram   = (i_addr <= RMSL_RAM_TOP);                 // [R01]
  wire in_seg   = (i_addr >= RMSL_SEG_BASE) &&
                  (i_addr <= RMSL_SEG_TOP);                 // [R09]
  wire in_misc  = (i_addr[23:2] == RMSL_KEY_ADDR[23:2]) &&
                  (i_addr[1:0] >= RMSL_KEY_ADDR[1:0]);      // [R12]
  wire in_per1  = (i_addr >= RMSL_PER1_BASE) &&
                  (i_addr <= RMSL_PER1_TOP);                // [R10]
  wire in_per2  = (i_addr >= RMSL_PER2_BASE) &&
                  (i_addr <= RMSL_PER2_TOP) && !in_seg && !in_misc;
  wire in_core  = (i_addr >= RMSL_CORE_BASE);               // [R11]
  wire in_ext   = in_per1 | in_per2 | in_core;
  wire w16_p1   = (i_addr >= RMSL_PER1_W16_LO) &&
                  (i_addr <= RMSL_PER1_W16_HI);
  wire w16_p2   = (i_addr >= RMSL_PER2_W16_LO) &&
                  (i_addr <= RMSL_PER2_W16_HI);

  // Device width per area
  wire [1:0] dw =
    in_ram                  ? RMSL_W32 :                    // [R14]
    (in_seg | in_misc)      ? RMSL_W16 :                    // [R12]
    (in_per1 & !w16_p1)     ? RMSL_W8  :
    (in_per2 & !w16_p2)     ? RMSL_W8  :
    in_ext                  ? RMSL_W16 : RMSL_W32;

  // Beat count and beat geometry
  wire [1:0] sz     = (i_size > RMSL_W32) ? RMSL_W32 : i_size;
  wire [1:0] bl     = (sz > dw) ? dw : sz;                  // Beat bytes log2
  wire [1:0] nlast  = (sz > dw) ? 2'((3'h1 << (sz - dw)) - 3'h1)
                                : 2'h0;                     // [R13]
  wire       last   = (beat_reg == nlast);
  wire [1:0] off    = 2'(beat_reg << dw);                   // Beat byte offset
  wire [23:0] a_b   = i_addr + {22'h0, off};                // Beat address
  wire [4:0] dsh    = {off, 3'b000};
  wire [31:0] bmask = (bl == RMSL_W8)  ? 32'h000000ff :
                      (bl == RMSL_W16) ? 32'h0000ffff : 32'hffffffff;
  wire [31:0] d_b   = (i_wdata >> dsh) & bmask;             // Beat data
  wire [3:0]  m_b   = (bl == RMSL_W8)  ? 4'h1 :
                      (bl == RMSL_W16) ? 4'h3 : 4'hf;

  // Usable RAM limit from size select and debug mode
  wire [11:0] lim   = i_debug_mode            ? RMSL_LIM_2K :  // [R04]
                      (sel_reg == RMSL_SZ_512) ? RMSL_LIM_512 : // [R03]
                      (sel_reg == RMSL_SZ_1K)  ? RMSL_LIM_1K  :
                                                 RMSL_LIM_2K;
  wire ram_ok   = in_ram && ({1'b0, a_b[10:0]} < lim);      // [R15]

  // Internal RAM lanes
  wire [8:0]  ram_idx = a_b[10:2];
  wire [4:0]  ram_sh  = {a_b[1:0], 3'b000};
  wire [3:0]  ram_be  = 4'(m_b << a_b[1:0]);
  wire [31:0] ram_wd  = d_b << ram_sh;
  wire        ram_we  = req & i_wr & ram_ok;
  wire [31:0] ram_rd  = ram_ok ? (ram[ram_idx] >> ram_sh) : 32'h0;

  // Display RAM lanes
  wire [4:0]  seg_off = 5'(a_b - RMSL_SEG_BASE);
  wire [1:0]  seg_be  = 2'(m_b << a_b[0]);
  wire [15:0] seg_wd  = 16'(d_b << {a_b[0], 3'b000});
  wire [15:0] seg_raw;
  wire [15:0] seg_rd  = seg_raw >> {a_b[0], 3'b000};

  // Misc register lanes
  wire        hit_key  = in_misc && (a_b[1] == RMSL_KEY_ADDR[1]);
  wire        hit_size = in_misc && (a_b[1] == RMSL_SIZE_ADDR[1]);
  wire [1:0]  misc_be  = 2'(m_b << a_b[0]);
  wire [15:0] misc_wd  = 16'(d_b << {a_b[0], 3'b000});
  wire [15:0] size_val = {7'h00, dbgsel_reg, 1'b0, RMSL_PRESENT,
                          1'b0, sel_reg};                   // [R07] [R16]
  wire [15:0] misc_raw = hit_key ? key_reg : size_val;
  wire [15:0] misc_rd  = misc_raw >> {a_b[0], 3'b000};
  wire        unlocked = (key_reg == RMSL_UNLOCK_KEY);      // [R05]
  wire        size_we  = req & i_wr & hit_size & unlocked;
  wire        sel_legal = (misc_wd[2:0] == RMSL_SZ_512) ||
                          (misc_wd[2:0] == RMSL_SZ_1K)  ||
                          (misc_wd[2:0] == RMSL_SZ_2K);     // [R16]

  // Peripheral beat outputs
  assign o_ext_req   = req & in_ext;
  assign o_ext_we    = i_wr;
  assign o_ext_area  = in_per1 ? 2'h0 : in_per2 ? 2'h1 : 2'h2;
  assign o_ext_addr  = a_b;
  assign o_ext_be    = (dw == RMSL_W8) ? 2'h1 : 2'(m_b << a_b[0]);
  assign o_ext_wdata = (dw == RMSL_W8) ? 16'(d_b)
                                       : 16'(d_b << {a_b[0], 3'b000});
  wire [15:0] ext_rd = (dw == RMSL_W8) ? {8'h00, i_ext_rdata[7:0]}
                                       : (i_ext_rdata >> {a_b[0], 3'b000});

  // Beat read value, unmapped reads as zero
  wire [31:0] r_b =
    in_ram  ? ram_rd :
    in_seg  ? {16'h0, seg_rd} :
    in_misc ? {16'h0, misc_rd} :
    in_ext  ? {16'h0, ext_rd} : 32'h0;
  wire [31:0] acc_next = (beat_reg == 2'h0) ? ((r_b & bmask) << dsh)
                         : (acc_reg | ((r_b & bmask) << dsh));

  // Debug base follows the select bit
  assign o_debug_base = dbgsel_reg ? RMSL_RAM_BASE : RMSL_CORE_BASE; // [R08]
  assign o_rdata      = rdata_reg;
  assign o_ready      = ready_reg;

  // Display RAM store
  rmsl_seg_ram #(
    .HALVES (RMSL_SEG_HALVES)
  ) u_seg (
    .i_mclk  (i_mclk),
    .i_we    (req & i_wr & in_seg),                         // [R09]
    .i_be    (seg_be),
    .i_index (seg_off[4:1]),
    .i_wdata (seg_wd),
    .o_rdata (seg_raw)
  );

  // Next state: one beat per cycle, then one answer cycle
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      RMSL_ST_RUN:  if (req && last) state_next = RMSL_ST_DONE; // [R13]
      RMSL_ST_DONE: state_next = RMSL_ST_RUN;
    endcase
  end

  // Sequencer registers
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_reg <= RMSL_ST_RUN;
      beat_reg  <= 2'h0;
      acc_reg   <= 32'h0;
      rdata_reg <= 32'h0;
      ready_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      ready_reg <= req & last;
      if (req) begin
        acc_reg  <= acc_next;
        beat_reg <= last ? 2'h0 : beat_reg + 2'h1;           // [R13]
        if (last && i_rd) begin
          rdata_reg <= acc_next;
        end
      end
    end
  end

  // Misc registers, key writable at any time
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      key_reg    <= RMSL_KEY_RESET;
      sel_reg    <= RMSL_SEL_RESET;                          // [R03]
      dbgsel_reg <= RMSL_DBGSEL_RST;                         // [R08]
    end else begin
      if (req && i_wr && hit_key && misc_be[0]) begin
        key_reg[7:0] <= misc_wd[7:0];
      end
      if (req && i_wr && hit_key && misc_be[1]) begin
        key_reg[15:8] <= misc_wd[15:8];
      end
      if (size_we && misc_be[0] && sel_legal) begin          // [R05] [R16]
        sel_reg <= misc_wd[2:0];
      end
      if (size_we && misc_be[1]) begin                       // [R05]
        dbgsel_reg <= misc_wd[RMSL_DBGSEL_BIT];
      end
    end
  end

  // Internal RAM, byte-lane writes in one cycle
  always_ff @(posedge i_mclk) begin
    for (int b = 0; b < 4; b++) begin
      if (ram_we && ram_be[b]) begin                         // [R01] [R15]
        ram[ram_idx][b*8 +: 8] <= ram_wd[b*8 +: 8];
      end
    end
  end

endmodule // rmsl_map

/* File: rtl/rmsl_pkg.sv */
// Constants for the RAM map and size limit block.
// Assumes a 24-bit CPU address and a 16-bit misc register group.
package rmsl_pkg;

  // Internal RAM window
  localparam logic [23:0] RMSL_RAM_BASE    = 24'h000000;
  localparam logic [23:0] RMSL_RAM_TOP     = 24'h0007ff;
  localparam int          RMSL_RAM_WORDS   = 512;
  localparam logic [23:0] RMSL_DBG_RAM_LO  = 24'h0007c0;
  // Display RAM window
  localparam logic [23:0] RMSL_SEG_BASE    = 24'h0053c0;
  localparam logic [23:0] RMSL_SEG_TOP     = 24'h0053d3;
  localparam int          RMSL_SEG_HALVES  = 10;
  // Peripheral areas
  localparam logic [23:0] RMSL_PER1_BASE   = 24'h004000;
  localparam logic [23:0] RMSL_PER1_TOP    = 24'h0043ff;
  localparam logic [23:0] RMSL_PER1_W16_LO = 24'h004200;
  localparam logic [23:0] RMSL_PER1_W16_HI = 24'h00437f;
  localparam logic [23:0] RMSL_PER2_BASE   = 24'h005000;
  localparam logic [23:0] RMSL_PER2_TOP    = 24'h005fff;
  localparam logic [23:0] RMSL_PER2_W16_LO = 24'h005300;
  localparam logic [23:0] RMSL_PER2_W16_HI = 24'h0053ff;
  // Core I/O window
  localparam logic [23:0] RMSL_CORE_BASE   = 24'hfffc00;
  // Misc registers
  localparam logic [23:0] RMSL_KEY_ADDR    = 24'h005324;
  localparam logic [23:0] RMSL_SIZE_ADDR   = 24'h005326;
  localparam logic [15:0] RMSL_UNLOCK_KEY  = 16'h0096;
  localparam logic [15:0] RMSL_KEY_RESET   = 16'h0000;
  // Size register fields
  localparam int          RMSL_SEL_LSB     = 0;
  localparam int          RMSL_PRES_LSB    = 4;
  localparam int          RMSL_DBGSEL_BIT  = 8;
  localparam logic [2:0]  RMSL_SZ_512      = 3'h5;
  localparam logic [2:0]  RMSL_SZ_1K       = 3'h4;
  localparam logic [2:0]  RMSL_SZ_2K       = 3'h3;
  localparam logic [2:0]  RMSL_SEL_RESET   = 3'h3;
  localparam logic [2:0]  RMSL_PRESENT     = 3'h3;
  localparam logic        RMSL_DBGSEL_RST  = 1'b0;
  localparam logic [11:0] RMSL_LIM_512     = 12'h200;
  localparam logic [11:0] RMSL_LIM_1K      = 12'h400;
  localparam logic [11:0] RMSL_LIM_2K      = 12'h800;
  // Access size and device width codes (log2 of bytes)
  localparam logic [1:0]  RMSL_W8          = 2'h0;
  localparam logic [1:0]  RMSL_W16         = 2'h1;
  localparam logic [1:0]  RMSL_W32         = 2'h2;
  // Sequencer states
  typedef enum logic {RMSL_ST_RUN = 1'b0, RMSL_ST_DONE = 1'b1} rmsl_state_t;

endpackage

/* File: rtl/rmsl_seg_ram.sv */
// Display RAM store: ten 16-bit halfwords with byte enables.
// Assumes the caller decodes the window and gives a halfword index.
`timescale 1ns/1ps
module rmsl_seg_ram
  import rmsl_pkg::*;
#(
  parameter int HALVES = RMSL_SEG_HALVES
) (
  input  wire logic        i_mclk,    // Core clock
  input  wire logic        i_we,      // Write this cycle
  input  wire logic [1:0]  i_be,      // Byte enables
  input  wire logic [3:0]  i_index,   // Halfword index
  input  wire logic [15:0] i_wdata,   // Write data
  output logic      [15:0] o_rdata    // Read data, same cycle
);

  logic [15:0] mem [HALVES];          // Storage, no reset

  // Out of range index reads as zero
  assign o_rdata = (32'(i_index) < HALVES) ? mem[i_index] : 16'h0000;

  // Byte-lane writes
  always_ff @(posedge i_mclk) begin
    for (int b = 0; b < 2; b++) begin
      if (i_we && i_be[b] && (32'(i_index) < HALVES)) begin
        mem[i_index][b*8 +: 8] <= i_wdata[b*8 +: 8];
      end
    end
  end

endmodule // rmsl_seg_ram

/* File: tb/rmsl_map_properties.sv */
// Port-level checks for the RAM map block, bound into its top module.
// Assumes one core clock and an active-low asynchronous reset.
`timescale 1ns/1ps
module rmsl_map_properties
  import rmsl_pkg::*;
#(
  parameter int RAM_WORDS = RMSL_RAM_WORDS  // Handed on, unused here
) (
  input wire logic        i_mclk,        // Core clock
  input wire logic        i_resetn,      // Async reset, active low
  input wire logic        i_rd,          // Read request
  input wire logic        i_wr,          // Write request
  input wire logic [1:0]  i_size,        // Access size code
  input wire logic [23:0] i_addr,        // CPU address
  input wire logic        o_ready,       // Access done pulse
  input wire logic        o_ext_req,     // Beat strobe
  input wire logic        o_ext_we,      // Beat is a write
  input wire logic [1:0]  o_ext_area,    // Beat area code
  input wire logic [23:0] o_ext_addr,    // Beat address
  input wire logic [1:0]  o_ext_be,      // Beat byte enables
  input wire logic [23:0] o_debug_base   // Debug base address
);
  // All checks share the core clock and its reset
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_resetn);
  wire logic req    = i_rd | i_wr;                   // Any request
  wire logic in_ram = i_addr <= RMSL_RAM_TOP;        // Internal RAM
  wire logic e8     = o_ext_addr[23:9] == 15'h0020;  // Lower 8-bit part, area 1
  wire logic e1     = o_ext_addr[23:10] == 14'h0010; // Whole area 1
  wire logic ecore  = o_ext_addr[23:10] == 14'h3fff; // Core I/O window

  ready_pulse_a: assert property (
    o_ready |=> !o_ready)
    else $error("done pulse longer than one cycle");
  ram_one_cycle_a: assert property (
    req && in_ram && !o_ready |=> o_ready)
    else $error("internal RAM access not done in one cycle");
  ram_no_beat_a: assert property (
    req && in_ram |-> !o_ext_req)
    else $error("internal RAM access leaked to peripheral bus");
  ready_cause_a: assert property (
    o_ready |-> $past(req))
    else $error("done pulse without a request");
  debug_base_a: assert property (
    o_debug_base == RMSL_CORE_BASE || o_debug_base == RMSL_RAM_BASE)
    else $error("debug base has an illegal value");
  beat_dir_a: assert property (
    o_ext_req |-> o_ext_we == i_wr && !o_ready)
    else $error("beat strobed in answer cycle or wrong direction");
  area_one_a: assert property (
    o_ext_req && e1 |-> o_ext_area == 2'h0)
    else $error("area 1 beat carries wrong area code");
  core_area_a: assert property (
    o_ext_req && ecore |-> o_ext_area == 2'h2)
    else $error("core I/O beat carries wrong area code");
  byte_lane_a: assert property (
    o_ext_req && e8 |-> o_ext_be == 2'b01)
    else $error("8-bit device beat uses wrong lane");
  beat_step_a: assert property (
    o_ext_req && e8 && i_size != 2'h0 && o_ext_addr == i_addr
    |=> o_ext_req && o_ext_addr == i_addr + 24'h1)
    else $error("second byte beat missing or misplaced");
endmodule // rmsl_map_properties

bind rmsl_map rmsl_map_properties #(.RAM_WORDS(RAM_WORDS)) u_props (
  .i_mclk(i_mclk), .i_resetn(i_resetn), .i_rd(i_rd), .i_wr(i_wr),
  .i_size(i_size), .i_addr(i_addr), .o_ready(o_ready),
  .o_ext_req(o_ext_req), .o_ext_we(o_ext_we), .o_ext_area(o_ext_area),
  .o_ext_addr(o_ext_addr), .o_ext_be(o_ext_be),
  .o_debug_base(o_debug_base)
);

/* File: tb/rmsl_periph_model.sv */
// Peripheral and core I/O responder at the far side of the map block.
// Assumes each beat is strobed for one cycle by the map block.
`timescale 1ns/1ps
module rmsl_periph_model (
  input  wire logic        i_mclk,   // Core clock
  input  wire logic        i_req,    // Beat strobe
  input  wire logic [23:0] i_addr,   // Beat address
  output logic      [15:0] o_rdata   // Beat read data
);
  logic idle_reg = 1'b0;  // Moving idle level, never a stale value
  // Idle pattern flips every cycle
  always_ff @(posedge i_mclk) begin
    idle_reg <= ~idle_reg;
  end
  // Same-cycle answer {~a, a} while strobed, else the moving pattern
  assign o_rdata = i_req ? {~i_addr[7:0], i_addr[7:0]} : {16{idle_reg}};
endmodule // rmsl_periph_model

/* File: tb/rmsl_map_bench.sv */
// Self-checking bench for the RAM map block.
// Assumes the peripheral responder model sits on the beat bus.
`timescale 1ns/1ps
module rmsl_map_bench
  import rmsl_pkg::*;
();
  logic        i_mclk = 1'b0;      // Core clock
  logic        i_resetn = 1'b0;    // Reset, active low
  logic        dbg = 1'b0;         // Debug mode level
  logic        rd = 1'b0;          // Read request
  logic        wr = 1'b0;          // Write request
  logic [1:0]  size = 2'h0;        // Access size
  logic [23:0] addr = 24'h0;       // Access address
  logic [31:0] wdata = 32'h0;      // Write data
  logic [31:0] rdata;              // Read data
  logic [31:0] got;                // Data taken at done
  logic        ready;              // Done pulse
  logic        ext_req;            // Beat strobe
  logic [23:0] ext_addr;           // Beat address
  logic [23:0] dbase;              // Debug base
  logic [15:0] ext_rdata;          // Responder data
  logic        ext_we;             // Beat is a write
  logic [1:0]  ext_be;             // Beat byte lanes
  logic [15:0] ext_wdata;          // Beat write data
  logic [41:0] wlog;               // Last write beat: addr, lanes, data
  int          num_errors = 0;     // Mismatches
  int          cmp_count = 0;      // Comparisons
  int          n;                  // Cycles to done
  // Read table: address, size, cycles, data
  logic [23:0] ta [7] = '{24'h4100, 24'h4100, 24'h4200, 24'h53c0,
                          24'hfffc00, 24'h5324, 24'h1000};
  logic [1:0]  ts [7] = '{2'h1, 2'h2, 2'h2, 2'h2, 2'h2, 2'h2, 2'h2};
  int          tn [7] = '{2, 4, 2, 2, 2, 2, 1};
  logic [31:0] td [7] = '{32'h0100, 32'h03020100, 32'hfd02ff00,
                          32'h89abcdef, 32'hfd02ff00, 32'h00330000, 32'h0};

  always #2 i_mclk = ~i_mclk;  // 250 MHz

  rmsl_map u_dut (
    .i_mclk(i_mclk), .i_resetn(i_resetn), .i_debug_mode(dbg),
    .i_rd(rd), .i_wr(wr), .i_size(size), .i_addr(addr),
    .i_wdata(wdata), .i_ext_rdata(ext_rdata), .o_rdata(rdata),
    .o_ready(ready), .o_ext_req(ext_req), .o_ext_we(ext_we),
    .o_ext_area(), .o_ext_addr(ext_addr), .o_ext_be(ext_be),
    .o_ext_wdata(ext_wdata), .o_debug_base(dbase)
  );

  rmsl_periph_model u_peri (
    .i_mclk(i_mclk), .i_req(ext_req), .i_addr(ext_addr),
    .o_rdata(ext_rdata)
  );

  // Keep the last write beat seen on the peripheral side
  always @(posedge i_mclk) begin
    if (ext_req && ext_we) begin
      wlog <= {ext_addr, ext_be, ext_wdata};
    end
  end

  // Compare one value, count it, report a mismatch
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // One access held until done; n counts cycles, idle cycle after
  task automatic acc(input logic w, input logic [1:0] s,
                     input logic [23:0] a, input logic [31:0] d);
    rd = !w;
    wr = w;
    size = s;
    addr = a;
    wdata = d;
    n = 0;
    do begin
      @(posedge i_mclk);
      #1;
      n++;
    end while (ready !== 1'b1 && n < 20);
    if (ready !== 1'b1) begin
      num_errors++;
      $display("mismatch at %0t: no done pulse", $time);
    end
    // Hold the request through the edge that samples done high
    @(posedge i_mclk);
    #1;
    got = rdata;
    rd = 1'b0;
    wr = 1'b0;
    @(posedge i_mclk);
    #1;
  endtask

  // Read and compare the data
  task automatic rchk(input logic [1:0] s, input logic [23:0] a,
                      input logic [31:0] e);
    acc(1'b0, s, a, 32'h0);
    chk(got, e);
  endtask

  // Counts, verdict, end of run
  task automatic close_out();
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // Watchdog far beyond the expected run of under a microsecond
  initial begin
    #100000;
    num_errors++;
    close_out();
  end

  // Main sequence
  initial begin
    repeat (12) @(posedge i_mclk);
    #1;
    i_resetn = 1'b1;
    rchk(2'h1, RMSL_SIZE_ADDR, 32'h33);
    chk({8'h0, dbase}, 32'hfffc00);
    acc(1'b1, 2'h2, 24'h0, 32'h1234abcd);
    chk(32'(n), 32'h1);
    rchk(2'h2, 24'h0, 32'h1234abcd);
    acc(1'b1, 2'h2, 24'h7fc, 32'hcafe0001);
    rchk(2'h0, 24'h7ff, 32'hca);
    acc(1'b1, 2'h2, 24'h53c0, 32'h89abcdef);
    acc(1'b1, 2'h1, 24'h53d2, 32'h5a5a);
    rchk(2'h1, 24'h53d2, 32'h5a5a);
    // Beat counts and assembled data per device width
    for (int i = 0; i < 7; i++) begin
      rchk(ts[i], ta[i], td[i]);
      chk(32'(n), 32'(tn[i]));
    end
    // Write beats: byte device gets low lane, 16-bit device by address
    acc(1'b1, 2'h1, 24'h4100, 32'hbeef);
    chk({8'h0, wlog[41:18]}, 32'h4101);
    chk({14'h0, wlog[17:0]}, 32'h100be);
    acc(1'b1, 2'h0, 24'h4201, 32'h5a);
    chk({8'h0, wlog[41:18]}, 32'h4201);
    chk({14'h0, wlog[17:0]}, 32'h25a00);
    acc(1'b1, 2'h1, RMSL_SIZE_ADDR, 32'h5);
    rchk(2'h1, RMSL_SIZE_ADDR, 32'h33);
    acc(1'b1, 2'h1, RMSL_KEY_ADDR, 32'h96);
    acc(1'b1, 2'h1, RMSL_SIZE_ADDR, 32'h5);
    rchk(2'h1, RMSL_SIZE_ADDR, 32'h35);
    acc(1'b1, 2'h2, 24'h1fc, 32'h11);
    rchk(2'h2, 24'h1fc, 32'h11);
    acc(1'b1, 2'h2, 24'h200, 32'h5555aaaa);
    rchk(2'h2, 24'h200, 32'h0);
    dbg = 1'b1;  // debug run stays off the top 64 bytes
    acc(1'b1, 2'h2, 24'h200, 32'h5555aaaa);
    acc(1'b1, 2'h2, 24'h400, 32'h77);
    rchk(2'h2, 24'h200, 32'h5555aaaa);
    dbg = 1'b0;
    rchk(2'h2, 24'h200, 32'h0);
    acc(1'b1, 2'h1, RMSL_SIZE_ADDR, 32'h4);
    rchk(2'h2, 24'h200, 32'h5555aaaa);
    rchk(2'h2, 24'h400, 32'h0);
    acc(1'b1, 2'h1, RMSL_SIZE_ADDR, 32'hffff);
    rchk(2'h1, RMSL_SIZE_ADDR, 32'h134);
    chk({8'h0, dbase}, 32'h0);
    acc(1'b1, 2'h1, RMSL_SIZE_ADDR, 32'h3);
    chk({8'h0, dbase}, 32'hfffc00);
    acc(1'b1, 2'h1, RMSL_KEY_ADDR, 32'h0);
    acc(1'b1, 2'h1, RMSL_SIZE_ADDR, 32'h5);
    rchk(2'h1, RMSL_SIZE_ADDR, 32'h33);
    rchk(2'h2, 24'h400, 32'h77);
    close_out();
  end
endmodule // rmsl_map_bench
